// File: logic/compare_shift_datapath.sv
`timescale 1ns/1ps
module compare_shift_datapath (
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	input  wire logic [7:0]             user_config_byte_zero,
	input  wire logic                   start,
	input  wire datapath_pkg::op_t      op,
	input  wire datapath_pkg::form_t    form,
	input  wire datapath_pkg::width_t   width,
	input  wire datapath_pkg::space_t   space,
	input  wire logic [3:0]             wait_states,
	input  wire logic [31:0]            dst_operand,
	input  wire logic [31:0]            src_operand,
	output wire logic                   busy,
	output logic                        source_mode,
	output logic [2:0]                  instr_bytes,
	output logic [7:0]                  instr_states,
	output logic                        done,
	output logic                        write_back,
	output logic [31:0]                 result,
	output logic                        carry_flag,
	output logic                        zero_flag,
	output logic                        sign_flag
);
	// ********************************
	// Helpers
	// ********************************
	function automatic logic [31:0] mask_of(input datapath_pkg::width_t w);
		case (w)
			datapath_pkg::width_byte: mask_of = 32'h0000_00ff;
			datapath_pkg::width_word: mask_of = 32'h0000_ffff;
			default:                  mask_of = 32'hffff_ffff;
		endcase
	endfunction : mask_of

	function automatic logic [31:0] top_of(input datapath_pkg::width_t w);
		case (w)
			datapath_pkg::width_byte: top_of = 32'h0000_0080;
			datapath_pkg::width_word: top_of = 32'h0000_8000;
			default:                  top_of = 32'h8000_0000;
		endcase
	endfunction : top_of

	function automatic datapath_pkg::timing_t pick(input logic s, input datapath_pkg::timing_t b,
		input datapath_pkg::timing_t r);
		pick = s ? r : b;
	endfunction : pick

	// Base encoding length and state count of one instruction
	function automatic datapath_pkg::timing_t base_timing(input logic s, input datapath_pkg::op_t o,
		input datapath_pkg::form_t f, input datapath_pkg::width_t w);
		base_timing = pick(s, datapath_pkg::BIN_SHIFT, datapath_pkg::SRC_SHIFT);
		if (o == datapath_pkg::swap_nibble_op)
			base_timing = datapath_pkg::ANY_SWAP;
		else if (o == datapath_pkg::compare_op) begin
			case (f)
				datapath_pkg::form_reg_reg: begin
					if (w == datapath_pkg::width_byte)
						base_timing = pick(s, datapath_pkg::BIN_RR_BYTE, datapath_pkg::SRC_RR_BYTE);
					else if (w == datapath_pkg::width_word)
						base_timing = pick(s, datapath_pkg::BIN_RR_WORD, datapath_pkg::SRC_RR_WORD);
					else
						base_timing = pick(s, datapath_pkg::BIN_RR_DWORD, datapath_pkg::SRC_RR_DWORD);
				end
				datapath_pkg::form_reg_imm: begin
					if (w == datapath_pkg::width_byte)
						base_timing = pick(s, datapath_pkg::BIN_IMM_BYTE, datapath_pkg::SRC_IMM_BYTE);
					else
						base_timing = pick(s, datapath_pkg::BIN_IMM_WORD, datapath_pkg::SRC_IMM_WORD);
				end
				datapath_pkg::form_dword_imm_zero,
				datapath_pkg::form_dword_imm_one:
					base_timing = pick(s, datapath_pkg::BIN_IMM_DW, datapath_pkg::SRC_IMM_DW);
				datapath_pkg::form_dir8: begin
					if (w == datapath_pkg::width_byte)
						base_timing = pick(s, datapath_pkg::BIN_D8_BYTE, datapath_pkg::SRC_D8_BYTE);
					else
						base_timing = pick(s, datapath_pkg::BIN_D8_WORD, datapath_pkg::SRC_D8_WORD);
				end
				datapath_pkg::form_dir16: begin
					if (w == datapath_pkg::width_byte)
						base_timing = pick(s, datapath_pkg::BIN_D16_BYTE, datapath_pkg::SRC_D16_BYTE);
					else
						base_timing = pick(s, datapath_pkg::BIN_D16_WORD, datapath_pkg::SRC_D16_WORD);
				end
				datapath_pkg::form_ind_word:
					base_timing = pick(s, datapath_pkg::BIN_IND_W, datapath_pkg::SRC_IND_W);
				datapath_pkg::form_ind_dword:
					base_timing = pick(s, datapath_pkg::BIN_IND_D, datapath_pkg::SRC_IND_D);
				default:
					base_timing = pick(s, datapath_pkg::BIN_RR_BYTE, datapath_pkg::SRC_RR_BYTE);
			endcase
		end
	endfunction : base_timing

	// States added by where the memory operand lives
	function automatic logic [7:0] extra_states(input datapath_pkg::op_t o, input datapath_pkg::form_t f,
		input datapath_pkg::width_t w, input datapath_pkg::space_t sp, input logic [3:0] n);
		logic [7:0] ext;
		ext = {4'h0, n} + datapath_pkg::EXT_BASE_EXTRA;
		extra_states = 8'h00;
		if (o == datapath_pkg::compare_op) begin
			if (f == datapath_pkg::form_dir8) begin
				if (sp == datapath_pkg::space_port)
					extra_states = (w == datapath_pkg::width_byte) ? datapath_pkg::PORT_BYTE_EXTRA
						: datapath_pkg::PORT_WORD_EXTRA;
				else if (sp == datapath_pkg::space_sfr)
					extra_states = (w == datapath_pkg::width_byte) ? datapath_pkg::SFR_BYTE_EXTRA
						: datapath_pkg::SFR_WORD_EXTRA;
			end else if ((f == datapath_pkg::form_dir16 || f == datapath_pkg::form_ind_word
				|| f == datapath_pkg::form_ind_dword) && sp == datapath_pkg::space_external)
				extra_states = (w == datapath_pkg::width_byte) ? ext : {ext[6:0], 1'h0};
		end
	endfunction : extra_states

	// ********************************
	// Decode and arithmetic
	// ********************************
	op_timer_if tmr ();

	datapath_pkg::timing_t base;
	logic [7:0]            total_states;
	logic                  accept;
	logic [31:0]           mask;
	logic [31:0]           top;
	logic [31:0]           dst_m;
	logic [31:0]           src_m;
	logic [32:0]           diff;
	logic [31:0]           shl_val;
	logic [31:0]           shr_val;
	logic [31:0]           sra_val;
	logic [31:0]           swap_val;
	logic [31:0]           next_result;
	logic                  next_carry;
	logic                  next_wb;
	logic                  next_flags;

	assign base         = base_timing(source_mode, op, form, width);
	assign total_states = base.states + extra_states(op, form, width, space, wait_states);
	assign accept       = start && !tmr.busy;
	assign busy         = tmr.busy;
	assign tmr.load        = accept;
	assign tmr.load_states = total_states;

	assign mask  = mask_of(width);
	assign top   = top_of(width);
	assign dst_m = dst_operand & mask;
	assign src_m = (form == datapath_pkg::form_dword_imm_zero) ? {16'h0000, src_operand[15:0]}
		: (form == datapath_pkg::form_dword_imm_one) ? {16'hffff, src_operand[15:0]}
		: src_operand & mask;
	assign diff     = {1'h0, dst_m} - {1'h0, src_m};
	assign shl_val  = (dst_m << 1) & mask;
	assign shr_val  = dst_m >> 1;
	assign sra_val  = shr_val | (dst_m & top);
	assign swap_val = {24'h000000, dst_operand[3:0], dst_operand[7:4]};

	always_comb begin
		next_result = diff[31:0] & mask;
		next_carry  = diff[32];
		next_wb     = 1'h1;
		next_flags  = 1'h1;
		case (op)
			datapath_pkg::compare_op: begin
				next_wb = 1'h0;
			end
			datapath_pkg::shift_left_logical_op: begin
				next_result = shl_val;
				next_carry  = |(dst_m & top);
			end
			datapath_pkg::shift_right_arith_op: begin
				next_result = sra_val;
				next_carry  = dst_m[0];
			end
			datapath_pkg::shift_right_logical_op: begin
				next_result = shr_val;
				next_carry  = dst_m[0];
			end
			datapath_pkg::swap_nibble_op: begin
				next_result = swap_val;
				next_flags  = 1'h0;
			end
			default: begin
				next_wb    = 1'h0;
				next_flags = 1'h0;
			end
		endcase
	end

	state_timer u_timer (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.tmr     (tmr.timer)
	);

	// ********************************
	// Pending and visible state
	// ********************************
	logic [31:0]           pend_result;
	logic                  pend_carry;
	logic                  pend_zero;
	logic                  pend_sign;
	logic                  pend_wb;
	logic                  pend_flags;
	logic                  next_zero;
	logic                  next_sign;

	assign next_zero = (next_result == 32'h0000_0000);
	assign next_sign = |(next_result & top);

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			source_mode <= (user_config_byte_zero[datapath_pkg::SRC_MODE_BIT]
				== datapath_pkg::SRC_MODE_LEVEL);
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			instr_bytes  <= 3'h0;
			instr_states <= 8'h00;
			pend_result  <= 32'h0000_0000;
			pend_carry   <= 1'h0;
			pend_zero    <= 1'h0;
			pend_sign    <= 1'h0;
			pend_wb      <= 1'h0;
			pend_flags   <= 1'h0;
		end else if (accept) begin
			instr_bytes  <= base.bytes;
			instr_states <= total_states;
			pend_result  <= next_result;
			pend_carry   <= next_carry;
			pend_zero    <= next_zero;
			pend_sign    <= next_sign;
			pend_wb      <= next_wb;
			pend_flags   <= next_flags;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			done       <= 1'h0;
			write_back <= 1'h0;
			result     <= 32'h0000_0000;
			carry_flag <= 1'h0;
			zero_flag  <= 1'h0;
			sign_flag  <= 1'h0;
		end else begin
			done       <= tmr.finish;
			write_back <= tmr.finish && pend_wb;
			if (tmr.finish)
				result <= pend_result;
			if (tmr.finish && pend_flags) begin
				carry_flag <= pend_carry;
				zero_flag  <= pend_zero;
				sign_flag  <= pend_sign;
			end
		end
	end

	// ********************************
	// Checks
	// ********************************
	logic [7:0] elapsed;

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			elapsed <= 8'h00;
		else if (accept)
			elapsed <= 8'h00;
		else
			elapsed <= elapsed + 8'h01;
	end

	property p_mode_fixed;
		@(posedge sys_clk) disable iff (!nrst)
		$past(nrst) |-> $stable(source_mode);
	endproperty
	a_mode_fixed: assert property (p_mode_fixed) else $error("opcode mode changed");

	property p_cmp_word_rr;
		@(posedge sys_clk) disable iff (!nrst)
		accept && op == datapath_pkg::compare_op && form == datapath_pkg::form_reg_reg
			&& width == datapath_pkg::width_word
		|=> instr_bytes == (source_mode ? 3'h2 : 3'h3) && instr_states == (source_mode ? 8'h02 : 8'h03);
	endproperty
	a_cmp_word_rr: assert property (p_cmp_word_rr) else $error("word compare timing wrong");

	property p_cmp_dword_rr;
		@(posedge sys_clk) disable iff (!nrst)
		accept && op == datapath_pkg::compare_op && form == datapath_pkg::form_reg_reg
			&& width == datapath_pkg::width_dword
		|=> instr_states == (source_mode ? 8'h04 : 8'h05);
	endproperty
	a_cmp_dword_rr: assert property (p_cmp_dword_rr) else $error("dword compare timing wrong");

	property p_ext_word;
		@(posedge sys_clk) disable iff (!nrst)
		accept && op == datapath_pkg::compare_op && form == datapath_pkg::form_dir16
			&& width == datapath_pkg::width_word && space == datapath_pkg::space_external
		|=> instr_states == (source_mode ? 8'h03 : 8'h04) + {3'h0, $past(wait_states), 1'h0} + 8'h04;
	endproperty
	a_ext_word: assert property (p_ext_word) else $error("external word states wrong");

	property p_done_latency;
		@(posedge sys_clk) disable iff (!nrst)
		done |-> elapsed == instr_states && !tmr.busy;
	endproperty
	a_done_latency: assert property (p_done_latency) else $error("done not at state count");

	property p_sll_byte;
		@(posedge sys_clk) disable iff (!nrst)
		accept && op == datapath_pkg::shift_left_logical_op && width == datapath_pkg::width_byte
		|=> pend_result == {24'h000000, $past(dst_operand[6:0]), 1'h0} && pend_carry == $past(dst_operand[7]);
	endproperty
	a_sll_byte: assert property (p_sll_byte) else $error("left shift wrong");

	property p_sra_word;
		@(posedge sys_clk) disable iff (!nrst)
		accept && op == datapath_pkg::shift_right_arith_op && width == datapath_pkg::width_word
		|=> pend_result[15:0] == {$past(dst_operand[15]), $past(dst_operand[15:1])}
			&& pend_carry == $past(dst_operand[0]);
	endproperty
	a_sra_word: assert property (p_sra_word) else $error("arithmetic shift wrong");

	property p_swap;
		@(posedge sys_clk) disable iff (!nrst)
		accept && op == datapath_pkg::swap_nibble_op
		|=> pend_result[7:0] == {$past(dst_operand[3:0]), $past(dst_operand[7:4])} && instr_states == 8'h02;
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_cmp_no_write;
		@(posedge sys_clk) disable iff (!nrst)
		accept && op == datapath_pkg::compare_op
		|=> !pend_wb && pend_carry == ($past(dst_m) < $past(src_m));
	endproperty
	a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare result wrong");

	property p_shift_write;
		@(posedge sys_clk) disable iff (!nrst)
		done && pend_wb |-> write_back && (!pend_flags || zero_flag == (result == 32'h0000_0000));
	endproperty
	a_shift_write: assert property (p_shift_write) else $error("shift write back wrong");

endmodule : compare_shift_datapath

// File: logic/datapath_pkg.sv
package datapath_pkg;

	typedef enum logic [2:0] {
		compare_op,
		shift_left_logical_op,
		shift_right_arith_op,
		shift_right_logical_op,
		swap_nibble_op
	} op_t;

	typedef enum logic [3:0] {
		form_reg_reg,
		form_reg_imm,
		form_dword_imm_zero,
		form_dword_imm_one,
		form_dir8,
		form_dir16,
		form_ind_word,
		form_ind_dword,
		form_none
	} form_t;

	typedef enum logic [1:0] {
		width_byte,
		width_word,
		width_dword
	} width_t;

	typedef enum logic [1:0] {
		space_internal,
		space_port,
		space_sfr,
		space_external
	} space_t;

	typedef struct packed {
		logic [2:0] bytes;
		logic [7:0] states;
	} timing_t;

	// ********************************
	// Mode strap
	// ********************************
	localparam int         SRC_MODE_BIT   = 0;
	localparam logic       SRC_MODE_LEVEL = 1'h1;

	// ********************************
	// Base lengths and states
	// ********************************
	localparam timing_t BIN_RR_BYTE  = '{3'h3, 8'h02};
	localparam timing_t SRC_RR_BYTE  = '{3'h2, 8'h01};
	localparam timing_t BIN_RR_WORD  = '{3'h3, 8'h03};
	localparam timing_t SRC_RR_WORD  = '{3'h2, 8'h02};
	localparam timing_t BIN_RR_DWORD = '{3'h3, 8'h05};
	localparam timing_t SRC_RR_DWORD = '{3'h2, 8'h04};
	localparam timing_t BIN_IMM_BYTE = '{3'h4, 8'h03};
	localparam timing_t SRC_IMM_BYTE = '{3'h3, 8'h02};
	localparam timing_t BIN_IMM_WORD = '{3'h5, 8'h04};
	localparam timing_t SRC_IMM_WORD = '{3'h4, 8'h03};
	localparam timing_t BIN_IMM_DW   = '{3'h5, 8'h06};
	localparam timing_t SRC_IMM_DW   = '{3'h4, 8'h05};
	localparam timing_t BIN_D8_BYTE  = '{3'h4, 8'h03};
	localparam timing_t SRC_D8_BYTE  = '{3'h3, 8'h02};
	localparam timing_t BIN_D8_WORD  = '{3'h4, 8'h04};
	localparam timing_t SRC_D8_WORD  = '{3'h3, 8'h03};
	localparam timing_t BIN_D16_BYTE = '{3'h5, 8'h03};
	localparam timing_t SRC_D16_BYTE = '{3'h4, 8'h02};
	localparam timing_t BIN_D16_WORD = '{3'h5, 8'h04};
	localparam timing_t SRC_D16_WORD = '{3'h4, 8'h03};
	localparam timing_t BIN_IND_W    = '{3'h4, 8'h03};
	localparam timing_t SRC_IND_W    = '{3'h3, 8'h02};
	localparam timing_t BIN_IND_D    = '{3'h4, 8'h04};
	localparam timing_t SRC_IND_D    = '{3'h3, 8'h03};
	localparam timing_t BIN_SHIFT    = '{3'h3, 8'h02};
	localparam timing_t SRC_SHIFT    = '{3'h2, 8'h01};
	localparam timing_t ANY_SWAP     = '{3'h1, 8'h02};

	// ********************************
	// Added states
	// ********************************
	localparam logic [7:0] PORT_BYTE_EXTRA = 8'h01;
	localparam logic [7:0] SFR_BYTE_EXTRA  = 8'h02;
	localparam logic [7:0] PORT_WORD_EXTRA = 8'h02;
	localparam logic [7:0] SFR_WORD_EXTRA  = 8'h03;
	localparam logic [7:0] EXT_BASE_EXTRA  = 8'h02;

endpackage : datapath_pkg

// File: logic/op_timer_if.sv
`timescale 1ns/1ps
interface op_timer_if;
	logic       load;
	logic [7:0] load_states;
	logic       busy;
	logic       finish;

	modport ctrl  (output load, output load_states, input busy, input finish);
	modport timer (input load, input load_states, output busy, output finish);
endinterface : op_timer_if

// File: logic/state_timer.sv
`timescale 1ns/1ps
module state_timer (
	input  wire logic sys_clk,
	input  wire logic nrst,
	op_timer_if.timer tmr
);
	logic [7:0] count;
	logic [7:0] next_count;

	assign next_count = tmr.load ? tmr.load_states
		: (count != 8'h00) ? count - 8'h01 : count;
	assign tmr.busy   = (count != 8'h00);
	assign tmr.finish = (count == 8'h01);

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			count <= 8'h00;
		else
			count <= next_count;
	end
endmodule : state_timer

// File: dv/reg_file_model.sv
`timescale 1ns/1ps
// ****************************************
// Register file holding the destination
// ****************************************
module reg_file_model (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        load,
	input  wire logic [31:0] load_value,
	input  wire logic        write_back,
	input  wire logic [31:0] result,
	output logic      [31:0] reg_value
);
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reg_value <= 32'h0;
		end else if (load) begin
			reg_value <= load_value;
		end else if (write_back) begin
			reg_value <= result;
		end
	end
endmodule : reg_file_model

// File: dv/compare_shift_datapath_test.sv
`timescale 1ns/1ps
module compare_shift_datapath_test;
	// ****************************************
	// Signals
	// ****************************************
	logic                  sys_clk = 1'b0;
	logic                  nrst = 1'b0;
	logic [7:0]            cfg = 8'h0;
	logic                  start = 1'b0;
	datapath_pkg::op_t     op = datapath_pkg::compare_op;
	datapath_pkg::form_t   form = datapath_pkg::form_reg_reg;
	datapath_pkg::width_t  width = datapath_pkg::width_byte;
	datapath_pkg::space_t  space = datapath_pkg::space_internal;
	logic [3:0]            wait_states = 4'h0;
	logic [31:0]           src_operand = 32'h0;
	logic                  load = 1'b0;
	logic [31:0]           load_value = 32'h0;
	logic [31:0]           reg_value;
	logic                  busy, source_mode, done, write_back, carry_flag, zero_flag, sign_flag;
	logic [2:0]            instr_bytes;
	logic [7:0]            instr_states;
	logic [31:0]           result;
	logic                  mode = 1'b0;
	int                    num_errors = 0;
	int                    compares = 0;

	always #4 sys_clk = ~sys_clk;

	compare_shift_datapath dut_u (.sys_clk(sys_clk), .nrst(nrst), .user_config_byte_zero(cfg), .start(start),
		.op(op), .form(form), .width(width), .space(space), .wait_states(wait_states),
		.dst_operand(reg_value), .src_operand(src_operand), .busy(busy), .source_mode(source_mode),
		.instr_bytes(instr_bytes), .instr_states(instr_states), .done(done), .write_back(write_back),
		.result(result), .carry_flag(carry_flag), .zero_flag(zero_flag), .sign_flag(sign_flag));

	reg_file_model model_u (.sys_clk(sys_clk), .nrst(nrst), .load(load), .load_value(load_value),
		.write_back(write_back), .result(result), .reg_value(reg_value));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic do_reset(input logic [7:0] c);
		@(posedge sys_clk);
		nrst <= 1'b0;
		cfg  <= c;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		#1;
		mode = c[0];
		check(source_mode, mode);
		check({busy, done, write_back}, 3'h0);
		$display("test reset end");
	endtask : do_reset

	task automatic run(input datapath_pkg::op_t o, input datapath_pkg::form_t f, input datapath_pkg::width_t w,
		input datapath_pkg::space_t sp, input logic [3:0] n, input logic [31:0] d, input logic [31:0] s,
		output int cnt, output logic wb);
		@(posedge sys_clk);
		load       <= 1'b1;
		load_value <= d;
		@(posedge sys_clk);
		load        <= 1'b0;
		start       <= 1'b1;
		op          <= o;
		form        <= f;
		width       <= w;
		space       <= sp;
		wait_states <= n;
		src_operand <= s;
		@(posedge sys_clk);
		start <= 1'b0;
		#1;
		check(busy, 1'b1);
		cnt = 0;
		while (done !== 1'b1 && cnt < 300) begin
			@(posedge sys_clk);
			#1;
			cnt++;
		end
		if (cnt >= 300) begin
			num_errors++;
			complete_run();
		end
		check(busy, 1'b0);
		wb = write_back;
	endtask : run

	task automatic time_case(input datapath_pkg::form_t f, input datapath_pkg::width_t w,
		input datapath_pkg::space_t sp, input logic [3:0] n, input int bb, input int bs, input int sb, input int ss);
		int   cnt;
		logic wb;
		run(datapath_pkg::compare_op, f, w, sp, n, 32'h0, 32'h0, cnt, wb);
		check(32'(instr_bytes), mode ? sb : bb);
		check(32'(instr_states), mode ? ss : bs);
		check(32'(cnt), mode ? ss : bs);
	endtask : time_case

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic timing_table;
		time_case(datapath_pkg::form_reg_reg, datapath_pkg::width_word, datapath_pkg::space_internal,
			4'h0, 3, 3, 2, 2);
		time_case(datapath_pkg::form_reg_reg, datapath_pkg::width_dword, datapath_pkg::space_internal,
			4'h0, 3, 5, 2, 4);
		time_case(datapath_pkg::form_reg_imm, datapath_pkg::width_byte, datapath_pkg::space_internal,
			4'h0, 4, 3, 3, 2);
		time_case(datapath_pkg::form_reg_imm, datapath_pkg::width_word, datapath_pkg::space_internal,
			4'h0, 5, 4, 4, 3);
		time_case(datapath_pkg::form_dword_imm_zero, datapath_pkg::width_dword,
			datapath_pkg::space_internal, 4'h0, 5, 6, 4, 5);
		time_case(datapath_pkg::form_dword_imm_one, datapath_pkg::width_dword,
			datapath_pkg::space_internal, 4'h0, 5, 6, 4, 5);
		time_case(datapath_pkg::form_dir8, datapath_pkg::width_byte, datapath_pkg::space_internal,
			4'h0, 4, 3, 3, 2);
		time_case(datapath_pkg::form_dir8, datapath_pkg::width_word, datapath_pkg::space_internal,
			4'h0, 4, 4, 3, 3);
		time_case(datapath_pkg::form_dir16, datapath_pkg::width_byte, datapath_pkg::space_internal,
			4'h0, 5, 3, 4, 2);
		time_case(datapath_pkg::form_dir16, datapath_pkg::width_word, datapath_pkg::space_internal,
			4'h0, 5, 4, 4, 3);
		time_case(datapath_pkg::form_ind_word, datapath_pkg::width_byte, datapath_pkg::space_internal,
			4'h0, 4, 3, 3, 2);
		time_case(datapath_pkg::form_ind_dword, datapath_pkg::width_byte, datapath_pkg::space_internal,
			4'h0, 4, 4, 3, 3);
		$display("test timing_table end");
	endtask : timing_table

	task automatic extra_states;
		time_case(datapath_pkg::form_dir8, datapath_pkg::width_byte, datapath_pkg::space_port,
			4'h0, 4, 4, 3, 3);
		time_case(datapath_pkg::form_dir8, datapath_pkg::width_byte, datapath_pkg::space_sfr,
			4'h0, 4, 5, 3, 4);
		time_case(datapath_pkg::form_dir8, datapath_pkg::width_word, datapath_pkg::space_port,
			4'h0, 4, 6, 3, 5);
		time_case(datapath_pkg::form_dir8, datapath_pkg::width_word, datapath_pkg::space_sfr,
			4'h0, 4, 7, 3, 6);
		time_case(datapath_pkg::form_dir16, datapath_pkg::width_byte, datapath_pkg::space_external,
			4'h3, 5, 8, 4, 7);
		time_case(datapath_pkg::form_ind_dword, datapath_pkg::width_byte, datapath_pkg::space_external,
			4'hf, 4, 21, 3, 20);
		time_case(datapath_pkg::form_dir16, datapath_pkg::width_word, datapath_pkg::space_external,
			4'h2, 5, 12, 4, 11);
		$display("test extra_states end");
	endtask : extra_states

	task automatic cmp_case(input datapath_pkg::form_t f, input datapath_pkg::width_t w, input logic [31:0] d,
		input logic [31:0] s, input logic [31:0] res, input logic [2:0] czs);
		int   cnt;
		logic wb;
		run(datapath_pkg::compare_op, f, w, datapath_pkg::space_internal, 4'h0, d, s, cnt, wb);
		check(result, res);
		check({carry_flag, zero_flag, sign_flag}, czs);
		check(wb, 1'b0);
		@(posedge sys_clk);
		#1;
		check(reg_value, d);
	endtask : cmp_case

	task automatic compare_values;
		cmp_case(datapath_pkg::form_reg_reg, datapath_pkg::width_byte, 32'h10, 32'h20, 32'hf0, 3'h5);
		cmp_case(datapath_pkg::form_reg_reg, datapath_pkg::width_word, 32'h1234, 32'h1234, 32'h0, 3'h2);
		cmp_case(datapath_pkg::form_dword_imm_one, datapath_pkg::width_dword,
			32'hffff8000, 32'h8000, 32'h0, 3'h2);
		cmp_case(datapath_pkg::form_dword_imm_zero, datapath_pkg::width_dword,
			32'h18000, 32'hffff8000, 32'h10000, 3'h0);
		$display("test compare_values end");
	endtask : compare_values

	task automatic shift_case(input datapath_pkg::op_t o, input datapath_pkg::width_t w, input logic [31:0] d,
		input logic [31:0] res, input logic [2:0] czs);
		int   cnt;
		logic wb;
		run(o, datapath_pkg::form_none, w, datapath_pkg::space_internal, 4'h0, d, 32'h0, cnt, wb);
		check(result, res);
		check({carry_flag, zero_flag, sign_flag}, czs);
		check(wb, 1'b1);
		check(32'(cnt), mode ? 32'h1 : 32'h2);
		check(32'(instr_bytes), mode ? 32'h2 : 32'h3);
		@(posedge sys_clk);
		#1;
		check(reg_value, res);
	endtask : shift_case

	task automatic shift_values;
		shift_case(datapath_pkg::shift_left_logical_op, datapath_pkg::width_byte, 32'hc1, 32'h82, 3'h5);
		shift_case(datapath_pkg::shift_left_logical_op, datapath_pkg::width_word, 32'h4000, 32'h8000, 3'h1);
		shift_case(datapath_pkg::shift_right_arith_op, datapath_pkg::width_byte, 32'h81, 32'hc0, 3'h5);
		shift_case(datapath_pkg::shift_right_arith_op, datapath_pkg::width_word, 32'h7ffe, 32'h3fff, 3'h0);
		shift_case(datapath_pkg::shift_right_logical_op, datapath_pkg::width_byte, 32'h81, 32'h40, 3'h4);
		shift_case(datapath_pkg::shift_right_logical_op, datapath_pkg::width_word, 32'h1, 32'h0, 3'h6);
		$display("test shift_values end");
	endtask : shift_values

	task automatic swap_value;
		int         cnt;
		logic       wb;
		logic [2:0] flags;
		flags = {carry_flag, zero_flag, sign_flag};
		run(datapath_pkg::swap_nibble_op, datapath_pkg::form_none, datapath_pkg::width_byte,
			datapath_pkg::space_internal, 4'h0, 32'ha5, 32'h0, cnt, wb);
		check(result, 32'h5a);
		check(wb, 1'b1);
		check(32'(cnt), 32'h2);
		check(32'(instr_bytes), 32'h1);
		check({carry_flag, zero_flag, sign_flag}, flags);
		@(posedge sys_clk);
		#1;
		check(reg_value, 32'h5a);
		$display("test swap_value end");
	endtask : swap_value

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		do_reset(8'hfe);
		timing_table();
		extra_states();
		compare_values();
		shift_values();
		swap_value();
		do_reset(8'h01);
		timing_table();
		extra_states();
		shift_values();
		swap_value();
		complete_run();
	end
endmodule : compare_shift_datapath_test
